// ===== core/spi_eeprom_bus_front_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_front_defs.svh"
// Summary of operation
// [RULE1] serial output changes on each falling serial clock edge
// [RULE2] serial input captured on each rising serial clock edge
// [RULE3] select high: deselected, output in high impedance
// [RULE4] deselected means standby, unless a write cycle still runs
// [RULE5] select low: selected and active power
// [RULE6] after power-up a select falling edge is needed first
// [RULE7] pause: output high impedance, input and clock ignored
// [RULE8] pause keeps the bit position; transfer resumes afterwards; the code resumes only if pause rises while clock is low
// [RULE9] master keeps select low while it asserts pause
// [RULE10] input bytes travel most significant bit first
// [RULE11] output bytes travel most significant bit first
// [RULE12] first input bit on first rising edge after select falls
// [RULE13] first output bit from first falling edge after last input bit
// [RULE14] master uses clock mode 0,0 or 1,1 only
// [RULE15] clock idles low in mode 0 and high in mode 1
// [RULE16] power-on reset clears latch and busy, keeps nonvolatile bits
// [RULE17] no response until reset ends; then deselected and standby
// [RULE18] master holds write protect steady during write instructions
// [RULE19] write protect locks the protect size bits; the code locks them, and the guard bit, only while the guard bit is set
// [RULE20] main array of 2048 bytes
// [RULE21] extra 32-byte page that can be locked read-only
// [RULE22] master deselects and waits for write end before power-off
// [RULE23] pause starts only if pause falls while clock is low
// [RULE24] bit counter and shifter reset whenever select goes high
module spi_eeprom_bus_front_end #(
   parameter int BUSY_CYCLES = `BUSY_CYCLES,
   parameter int DEPTH = `ARRAY_DEPTH,
   parameter int ID_DEPTH = `ID_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic sdi,
   input wire logic pause_n,
   input wire logic wprot_n,
   output logic sdo,
   output logic sdo_oe,
   output logic active_power,
   output logic selected,
   output logic paused,
   output logic rx_valid,
   output eeprom_front_pkg::byte_t rx_byte,
   output logic tx_load_req,
   input wire eeprom_front_pkg::byte_t tx_byte,
   input wire logic tx_enable,
   input wire logic set_write_latch,
   input wire logic clr_write_latch,
   input wire logic start_write,
   input wire logic [`ADDR_W-1:0] mem_addr,
   input wire logic mem_we,
   input wire eeprom_front_pkg::byte_t mem_wdata,
   output eeprom_front_pkg::byte_t mem_rdata,
   input wire logic id_sel,
   input wire logic id_lock,
   output logic id_locked,
   input wire logic status_we,
   input wire logic [`BYTE_W-1:0] status_wdata,
   output logic write_latch_flag,
   output logic write_busy_flag,
   output logic status_guard_bit,
   output logic protect_size_hi,
   output logic protect_size_lo
);
   initial begin
      if (DEPTH != `ARRAY_DEPTH) $error("front end: DEPTH must be 2048");
      if (ID_DEPTH != `ID_DEPTH) $error("front end: ID_DEPTH must be 32");
      if (BUSY_CYCLES < 1) $error("front end: BUSY_CYCLES below 1");
   end

   logic sck_rise, sck_fall, sck_q;
   logic sel_rise, sel_fall;
   logic pause_rise, pause_fall;
   logic wr_busy;

   // registered pin copies with edge pulses
   // a clock idling high gives one false rise, harmless while locked out
   edge_detect u_sck (
      .clk(clk),
      .sys_rst(sys_rst),
      .level_in(sclk),
      .reset_value(1'b0),
      .rise(sck_rise),
      .fall(sck_fall),
      .level_q(sck_q)
   );
   // reset at the idle level; lockout covers a select held low at power-up
   edge_detect u_sel (
      .clk(clk),
      .sys_rst(sys_rst),
      .level_in(sel_n),
      .reset_value(1'b1),
      .rise(sel_rise),
      .fall(sel_fall),
      .level_q()
   );
   edge_detect u_pause (
      .clk(clk),
      .sys_rst(sys_rst),
      .level_in(pause_n),
      .reset_value(1'b1),
      .rise(pause_rise),
      .fall(pause_fall),
      .level_q()
   );

   // internal write cycle timing
   busy_timer #(.CYCLES(BUSY_CYCLES)) u_busy (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(start_write),
      .busy(wr_busy)
   );

   eeprom_front_pkg::link_state_e state_q, state_d;
   logic [`BIT_CNT_W-1:0] bit_q, bit_d;
   eeprom_front_pkg::byte_t sh_q, sh_d, out_q, out_d;
   logic rxv_q, rxv_d;
   eeprom_front_pkg::byte_t rxb_q, rxb_d;
   logic sdo_q, sdo_d;
   logic load_q, load_d;
   logic armed_q, armed_d;

   // link state, bit counter and shifters
   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      sh_d = sh_q;
      out_d = out_q;
      rxv_d = 1'b0;
      rxb_d = rxb_q;
      sdo_d = sdo_q;
      load_d = 1'b0;
      armed_d = armed_q;
      if (sel_rise) begin
         armed_d = 1'b1;
      end
      case (state_q)
         eeprom_front_pkg::ST_LOCKOUT: begin
            // wait for select seen high before any selection [RULE6]
            if (sel_n || armed_q) begin
               state_d = eeprom_front_pkg::ST_IDLE;
            end
         end
         eeprom_front_pkg::ST_IDLE: begin
            if (sel_fall) begin // only an edge selects [RULE6] [RULE5]
               state_d = eeprom_front_pkg::ST_ACTIVE;
               bit_d = '0;
               sh_d = '0;
            end
         end
         eeprom_front_pkg::ST_ACTIVE: begin
            if (sel_n) begin
               state_d = eeprom_front_pkg::ST_IDLE; // [RULE3]
               bit_d = '0; // [RULE24]
               sh_d = '0;
            end else if (pause_fall && !sck_q && !sclk) begin
               state_d = eeprom_front_pkg::ST_PAUSE; // [RULE23]
            end else if (sck_rise) begin
               // msb first: shift toward the top [RULE2] [RULE10] [RULE12]
               sh_d = {sh_q[`MSB_POS-1:0], sdi};
               bit_d = bit_q + `BIT_CNT_W'(1);
               if (bit_q == `BIT_LAST) begin
                  rxv_d = 1'b1;
                  rxb_d = {sh_q[`MSB_POS-1:0], sdi};
                  load_d = 1'b1;
               end
            end else if (sck_fall && tx_enable) begin
               // output changes only on falling edges [RULE1] [RULE13]
               if (bit_q == '0) begin
                  out_d = {tx_byte[`MSB_POS-1:0], 1'b0};
                  sdo_d = tx_byte[`MSB_POS]; // [RULE11]
               end else begin
                  out_d = {out_q[`MSB_POS-1:0], 1'b0};
                  sdo_d = out_q[`MSB_POS];
               end
            end
         end
         eeprom_front_pkg::ST_PAUSE: begin
            // clock and input ignored; counters frozen [RULE7] [RULE8]
            if (sel_n) begin
               state_d = eeprom_front_pkg::ST_IDLE;
               bit_d = '0; // [RULE24]
               sh_d = '0;
            end else if (pause_rise && !sclk) begin
               state_d = eeprom_front_pkg::ST_ACTIVE;
            end
         end
         default: begin
            state_d = eeprom_front_pkg::ST_LOCKOUT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= eeprom_front_pkg::ST_LOCKOUT; // [RULE17]
         bit_q <= '0;
         sh_q <= '0;
         out_q <= '0;
         rxv_q <= 1'b0;
         rxb_q <= '0;
         sdo_q <= 1'b0;
         load_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         out_q <= out_d;
         rxv_q <= rxv_d;
         rxb_q <= rxb_d;
         sdo_q <= sdo_d;
         load_q <= load_d;
         armed_q <= armed_d;
      end
   end

   // pad drive: enabled only while selected, not paused [RULE3] [RULE7]
   assign sdo = sdo_q;
   assign sdo_oe = (state_q == eeprom_front_pkg::ST_ACTIVE) && !sel_n &&
                   tx_enable;
   assign selected = (state_q == eeprom_front_pkg::ST_ACTIVE) ||
                     (state_q == eeprom_front_pkg::ST_PAUSE);
   assign paused = (state_q == eeprom_front_pkg::ST_PAUSE);
   // standby only when deselected and no write runs [RULE4] [RULE5]
   assign active_power = selected || wr_busy;
   assign rx_valid = rxv_q;
   assign rx_byte = rxb_q;
   assign tx_load_req = load_q;
   assign write_busy_flag = wr_busy; // cleared by reset timer [RULE16]

   // volatile write latch; set beats clear
   logic wel_q, wel_d;
   always_comb begin
      wel_d = wel_q;
      if (clr_write_latch) begin
         wel_d = 1'b0;
      end
      if (set_write_latch) begin
         wel_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wel_q <= 1'b0; // [RULE16]
      end else begin
         wel_q <= wel_d;
      end
   end
   assign write_latch_flag = wel_q;

   // nonvolatile status bits: power-up value only, reset leaves them [RULE16]
   logic guard_q = 1'b0;
   logic bp1_q = 1'b0;
   logic bp0_q = 1'b0;
   logic guard_d, bp1_d, bp0_d;
   logic bp_locked;
   assign bp_locked = guard_q && !wprot_n;
   always_comb begin
      guard_d = guard_q;
      bp1_d = bp1_q;
      bp0_d = bp0_q;
      if (status_we && !bp_locked) begin // [RULE19]
         guard_d = status_wdata[`GUARD_POS];
         bp1_d = status_wdata[`PROT_HI_POS];
         bp0_d = status_wdata[`PROT_LO_POS];
      end
   end
   always_ff @(posedge clk) begin
      guard_q <= guard_d;
      bp1_q <= bp1_d;
      bp0_q <= bp0_d;
   end
   assign status_guard_bit = guard_q;
   assign protect_size_hi = bp1_q;
   assign protect_size_lo = bp0_q;

   // main array and identification page [RULE20] [RULE21]
   eeprom_front_pkg::byte_t mem [DEPTH];
   eeprom_front_pkg::byte_t id_mem [ID_DEPTH];
   logic lock_q = 1'b0;
   eeprom_front_pkg::byte_t rd_q;
   always_ff @(posedge clk) begin
      if (mem_we && !id_sel) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (mem_we && id_sel && !lock_q) begin // locked page is read-only
         id_mem[mem_addr[`ID_ADDR_W-1:0]] <= mem_wdata;
      end
      rd_q <= id_sel ? id_mem[mem_addr[`ID_ADDR_W-1:0]] : mem[mem_addr];
   end
   // lock is permanent; nonvolatile so reset leaves it
   always_ff @(posedge clk) begin
      if (id_lock) begin
         lock_q <= 1'b1;
      end
   end
   assign id_locked = lock_q;
   assign mem_rdata = rd_q;
endmodule // spi_eeprom_bus_front_end
`default_nettype wire

// ===== common/eeprom_front_defs.svh
`ifndef EEPROM_FRONT_DEFS_SVH
`define EEPROM_FRONT_DEFS_SVH
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define MSB_POS 7
`define GUARD_POS 7
`define PROT_HI_POS 3
`define PROT_LO_POS 2
`define ARRAY_DEPTH 2048
`define ID_DEPTH 32
`define ADDR_W 11
`define ID_ADDR_W 5
`define BUSY_TIME_MS 5
`define CLK_HZ 50000000
`define BUSY_CYCLES ((`CLK_HZ / 1000) * `BUSY_TIME_MS)
`endif

// ===== common/eeprom_front_pkg.sv
package eeprom_front_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_PAUSE = 2'b10,
      ST_LOCKOUT = 2'b11
   } link_state_e;
   typedef logic [7:0] byte_t;
endpackage

// ===== core/edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
// registered copy of a synchronous input with rise and fall pulses
module edge_detect (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic level_in,
   input wire logic reset_value,
   output logic rise,
   output logic fall,
   output logic level_q
);
   logic level_d;
   // next value is simply the input
   always_comb begin
      level_d = level_in;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level_q <= reset_value;
      end else begin
         level_q <= level_d;
      end
   end
   assign rise = level_in & ~level_q;
   assign fall = ~level_in & level_q;
endmodule // edge_detect
`default_nettype wire

// ===== core/busy_timer.sv
`timescale 1ns/100ps
`default_nettype none
// counts down a write cycle; busy while nonzero
module busy_timer #(
   parameter int CYCLES = 250000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   output logic busy
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   initial begin
      if (CYCLES < 1) $error("busy_timer: CYCLES must be at least 1");
   end
   // reload on start, otherwise run down to zero
   always_comb begin
      cnt_d = cnt_q;
      if (start) begin
         cnt_d = W'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign busy = (cnt_q != '0);
endmodule // busy_timer
`default_nettype wire

// ===== tb/spi_eeprom_bus_front_end_checker.sv
`timescale 1ns/100ps
`default_nettype none
// pin and flag relations of the front end, seen from its ports only
module spi_eeprom_bus_front_end_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic wprot_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic active_power,
   input wire logic selected,
   input wire logic paused,
   input wire logic rx_valid,
   input wire logic tx_load_req,
   input wire logic status_we,
   input wire logic write_latch_flag,
   input wire logic write_busy_flag,
   input wire logic status_guard_bit,
   input wire logic protect_size_hi,
   input wire logic protect_size_lo
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // three samples high so the registered state has caught up
   desel_quiet_a: assert property (sel_n && $past(sel_n) && $past(sel_n, 2) |-> !selected && !sdo_oe) else $error("driving while deselected");
   standby_idle_a: assert property (sel_n && $past(sel_n) && $past(sel_n, 2) && !write_busy_flag |-> !active_power) else $error("not in standby");
   sel_active_a: assert property (selected |-> active_power) else $error("selected without active power");
   pause_quiet_a: assert property (paused && $past(paused) |-> !sdo_oe && !rx_valid) else $error("activity during pause");
   rx_edge_a: assert property (rx_valid |-> ($past(sclk) || $past(sclk, 2)) && tx_load_req ##1 !rx_valid) else $error("byte not tied to a rising edge");
   sdo_fall_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !$past(sclk) || !$past(sclk, 2)) else $error("output moved off a falling edge");
   guard_lock_a: assert property (status_we && status_guard_bit && !wprot_n |=> $stable(protect_size_hi) && $stable(protect_size_lo) && status_guard_bit) else $error("protect size changed while locked");
   reset_clear_a: assert property (disable iff (1'b0) $past(sys_rst) |-> !selected && !write_latch_flag && !write_busy_flag) else $error("flags set under reset");
   pause_seen_c: cover property (paused);
endmodule // spi_eeprom_bus_front_end_checker
`default_nettype wire

// ===== tb/spi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// serial bus master; half period of three system clocks
module spi_master_model (
   input wire logic clk,
   input wire logic sdo,
   input wire logic cpol,
   output logic sclk,
   output logic sel_n,
   output logic sdi,
   output logic pause_n
);
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      sdi = 1'b0;
      pause_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // clock parked at its idle level in the same step as select moves
   task automatic select();
      sclk <= cpol;
      sel_n <= 1'b0;
      tick(3);
   endtask
   task automatic deselect();
      sclk <= cpol;
      sel_n <= 1'b1;
      sdi <= ~sdi; // released line shows no stale level
      tick(3);
   endtask
   // modes 0,0 and 1,1 only, msb first both ways
   task automatic xfer(input eeprom_front_pkg::byte_t tx, input int nbits,
                       input int hold_bit, output eeprom_front_pkg::byte_t rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         sclk <= 1'b0;
         sdi <= tx[i];
         tick(3);
         if (i == hold_bit) begin
            pause_n <= 1'b0; // clock low, select low
            tick(2);
            repeat (4) begin
               sdi <= ~sdi;
               sclk <= ~sclk;
               tick(2);
            end
            sdi <= tx[i];
            pause_n <= 1'b1;
            tick(3);
         end
         rx[i] = sdo;
         sclk <= 1'b1;
         tick(3);
      end
      if (!cpol) begin
         sclk <= 1'b0;
         tick(3);
      end
   endtask
endmodule // spi_master_model
`default_nettype wire

// ===== tb/tb_spi_eeprom_bus_front_end.sv
`timescale 1ns/100ps
`default_nettype none
module tb_spi_eeprom_bus_front_end;
   logic clk, sys_rst, cpol, sclk, sel_n, sdi, pause_n, wprot_n, sdo, sdo_oe;
   logic active_power, selected, paused, rx_valid, tx_load_req, tx_enable;
   logic set_write_latch, clr_write_latch, start_write, status_we;
   logic write_latch_flag, write_busy_flag, status_guard_bit;
   logic protect_size_hi, protect_size_lo;
   logic [7:0] status_wdata;
   logic mem_we, id_sel, id_lock, id_locked;
   logic [10:0] mem_addr;
   eeprom_front_pkg::byte_t mem_wdata, mem_rdata;
   eeprom_front_pkg::byte_t rx_byte, tx_byte, got;
   int n_errors, check_count;
   // undriven output line reads as the opposite level
   wire logic sdo_pin = sdo_oe ? sdo : ~sdo;
   spi_eeprom_bus_front_end #(.BUSY_CYCLES(10)) uut (
      .clk, .sys_rst, .sclk, .sel_n, .sdi, .pause_n, .wprot_n, .sdo, .sdo_oe,
      .active_power, .selected, .paused, .rx_valid, .rx_byte, .tx_load_req,
      .tx_byte, .tx_enable, .set_write_latch, .clr_write_latch, .start_write,
      .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .id_sel, .id_lock,
      .id_locked, .status_we, .status_wdata,
      .write_latch_flag, .write_busy_flag, .status_guard_bit,
      .protect_size_hi, .protect_size_lo);
   spi_master_model m (.clk, .sdo(sdo_pin), .cpol, .sclk, .sel_n, .sdi,
      .pause_n);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr_status(input logic [7:0] v);
      status_wdata <= v;
      status_we <= 1'b1;
      tick(1);
      status_we <= 1'b0;
      tick(2);
   endtask
   // one array write; read data of that address stands after it
   task automatic wr_mem(input logic s, input logic [10:0] a,
                         input logic [7:0] d);
      id_sel <= s;
      mem_addr <= a;
      mem_wdata <= d;
      mem_we <= 1'b1;
      tick(1);
      mem_we <= 1'b0;
      tick(2);
   endtask
   task automatic finish_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {sys_rst, wprot_n} = 2'b11;
      {cpol, tx_enable, set_write_latch, clr_write_latch} = 4'h0;
      {start_write, status_we} = 2'b00;
      {mem_we, id_sel, id_lock, mem_addr, mem_wdata} = 22'h000000;
      {status_wdata, tx_byte} = 16'h0000;
      n_errors = 0;
      check_count = 0;
      m.select(); // select already low while reset is held
      sys_rst <= 1'b0;
      tick(6);
      chk(selected, 1'b0);
      chk({write_latch_flag, write_busy_flag}, 2'b00);
      // both clock modes, back to back bytes, pause, partial byte
      for (int md = 0; md < 2; md++) begin
         cpol <= md[0];
         tick(1);
         m.deselect();
         chk(active_power, 1'b0);
         m.select();
         chk(selected, 1'b1);
         tx_byte <= 8'h3c ^ md[7:0];
         tx_enable <= 1'b1;
         m.xfer(8'ha5, 8, -1, got);
         chk(rx_byte, 8'ha5);
         m.xfer(8'h5a, 8, -1, got);
         chk(got, 8'h3c ^ md[7:0]);
         chk(rx_byte, 8'h5a);
         m.xfer(8'hc3, 8, 3, got);
         chk(rx_byte, 8'hc3);
         chk(got, 8'h3c ^ md[7:0]);
         m.xfer(8'hff, 3, -1, got);
         m.deselect();
         m.select();
         m.xfer(8'h96, 8, -1, got);
         chk(rx_byte, 8'h96);
      end
      // write cycle keeps the part active after deselect
      set_write_latch <= 1'b1;
      tick(1);
      set_write_latch <= 1'b0;
      start_write <= 1'b1;
      tick(1);
      start_write <= 1'b0;
      chk(write_latch_flag, 1'b1);
      m.deselect(); // master deselects before the write ends
      chk({write_busy_flag, active_power}, 2'b11);
      for (int i = 0; i < 40 && write_busy_flag !== 1'b0; i++) tick(1);
      // a write that never ends is counted as a failure
      if (write_busy_flag !== 1'b0) n_errors++;
      tick(3);
      chk({write_busy_flag, active_power}, 2'b00);
      clr_write_latch <= 1'b1;
      tick(1);
      clr_write_latch <= 1'b0;
      tick(2);
      chk(write_latch_flag, 1'b0);
      // protect size frozen by guard and write protect low
      wr_status(8'h8c);
      chk({status_guard_bit, protect_size_hi, protect_size_lo}, 3'h7);
      wprot_n <= 1'b0; // held steady over the status write
      wr_status(8'h00);
      chk({status_guard_bit, protect_size_hi, protect_size_lo}, 3'h7);
      wprot_n <= 1'b1;
      wr_status(8'h00);
      chk({status_guard_bit, protect_size_hi, protect_size_lo}, 3'h0);
      // main array at both ends, then the lockable identification page
      wr_mem(1'b0, 11'h7ff, 8'h69);
      wr_mem(1'b0, 11'h000, 8'h96);
      chk(mem_rdata, 8'h96);
      mem_addr <= 11'h7ff;
      tick(2);
      chk(mem_rdata, 8'h69);
      wr_mem(1'b1, 11'h01f, 8'h3c);
      chk(mem_rdata, 8'h3c);
      chk(id_locked, 1'b0);
      id_lock <= 1'b1;
      tick(1);
      id_lock <= 1'b0;
      wr_mem(1'b1, 11'h01f, 8'hc3);
      chk(mem_rdata, 8'h3c);
      chk(id_locked, 1'b1);
      wr_mem(1'b0, 11'h01f, 8'hc3);
      chk(mem_rdata, 8'hc3);
      finish_test();
   end
endmodule // tb_spi_eeprom_bus_front_end
bind spi_eeprom_bus_front_end spi_eeprom_bus_front_end_checker chk_i (
   .clk, .sys_rst, .sclk, .sel_n, .wprot_n, .sdo, .sdo_oe, .active_power,
   .selected, .paused, .rx_valid, .tx_load_req, .status_we, .write_latch_flag,
   .write_busy_flag, .status_guard_bit, .protect_size_hi, .protect_size_lo);
`default_nettype wire
